// *** pkg/ptic_pkg.sv ***
// Shared register map, field positions and codes for the paired timer and capture unit
`default_nettype none
package ptic_pkg;
    localparam logic [9:0] ADDR_LOW_COUNT = 10'h106;
    localparam logic [9:0] ADDR_HOLDING = 10'h108;
    localparam logic [9:0] ADDR_HIGH_COUNT = 10'h10a;
    localparam logic [9:0] ADDR_LOW_PERIOD = 10'h10c;
    localparam logic [9:0] ADDR_HIGH_PERIOD = 10'h10e;
    localparam logic [9:0] ADDR_LOW_CTRL = 10'h110;
    localparam logic [9:0] ADDR_HIGH_CTRL = 10'h112;
    localparam logic [9:0] ADDR_CAP0_BUF = 10'h140;
    localparam logic [9:0] ADDR_CAP0_CTRL = 10'h142;
    localparam logic [9:0] ADDR_CAP1_BUF = 10'h144;
    localparam logic [9:0] ADDR_CAP1_CTRL = 10'h146;
    localparam logic [9:0] ADDR_IRQ_FLAG = 10'h150;
    localparam logic [9:0] ADDR_IRQ_ENABLE = 10'h152;
    // Timer control fields
    localparam int TC_ON = 15;
    localparam int TC_IDLE = 13;
    localparam int TC_GATE = 6;
    localparam int TC_DIV_LO = 4;
    localparam int TC_WIDE = 3;
    localparam int TC_SRC = 1;
    // Capture control fields
    localparam int CC_IDLE = 13;
    localparam int CC_TB = 7;
    localparam int CC_ICNT_LO = 5;
    localparam int CC_OVF = 4;
    localparam int CC_BNE = 3;
    // Interrupt flag/enable bit positions
    localparam int IRQ_HIGH_TIMER = 7;
    localparam int IRQ_CAP0 = 1;
    localparam int IRQ_CAP1 = 5;
    localparam logic [15:0] PERIOD_RESET = 16'hffff;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam int CAP_DEPTH = 4;
    typedef enum logic [2:0] {
        CM_OFF = 3'b000,
        CM_EVERY_EDGE = 3'b001,
        CM_FALL = 3'b010,
        CM_RISE = 3'b011,
        CM_RISE4 = 3'b100,
        CM_RISE16 = 3'b101,
        CM_RSVD = 3'b110,
        CM_WAKE = 3'b111
    } cap_mode_t;
endpackage : ptic_pkg
`default_nettype wire

// *** pkg/cap_if.sv ***
// Link between the top and each capture channel
`default_nettype none
interface cap_if;
    logic [15:0] ctrl;
    logic ctrl_wr;
    logic [15:0] timebase;
    logic pin;
    logic rd;
    logic [15:0] head;
    logic not_empty;
    logic overflow;
    logic irq_pulse;
    logic wake;
    modport top (output ctrl, ctrl_wr, timebase, pin, rd,
        input head, not_empty, overflow, irq_pulse, wake);
    modport chan (input ctrl, ctrl_wr, timebase, pin, rd,
        output head, not_empty, overflow, irq_pulse, wake);
endinterface : cap_if
`default_nettype wire

// *** rtl/div_prescaler.sv ***
// Timer input prescaler giving a one-cycle count enable
`default_nettype none
module div_prescaler (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic clear,
    input wire logic [1:0] sel,
    output logic en
);
    logic [7:0] cnt_q;
    logic [7:0] top;
    // Terminal value of the divide ratio 1, 8, 64, 256 [R2]
    assign top = (sel == 2'd0) ? 8'h00 : (sel == 2'd1) ? 8'h07 :
                 (sel == 2'd2) ? 8'h3f : 8'hff;
    assign en = tick && (cnt_q == top);
    // Counter clears on request; [R4]
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 8'h00;
        end else if (clear) begin
            cnt_q <= 8'h00;
        end else if (tick) begin
            cnt_q <= (cnt_q == top) ? 8'h00 : cnt_q + 8'h01;
        end
    end
endmodule : div_prescaler
`default_nettype wire

// *** rtl/capture_channel.sv ***
// One capture channel: edge qualify, edge prescale, four-deep buffer
`default_nettype none
module capture_channel #(
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    cap_if.chan c
);
    import ptic_pkg::*;
    logic [15:0] mem_q [DEPTH];
    logic [2:0] fill_q;
    logic ovf_q, pin_q, locked_q;
    logic [3:0] pre_q;
    logic [1:0] icnt_q;
    logic [2:0] mode;
    logic rise, fall, edge_hit, store, full, pre_hit;
    assign mode = c.ctrl[2:0];
    assign rise = c.pin && !pin_q;
    assign fall = !c.pin && pin_q;
    assign pre_hit = (mode == CM_RISE4) ? (pre_q[1:0] == 2'd3) : (pre_q == 4'hf);
    // Edge qualification per mode [R10]
    always_comb begin
        case (mode)
            CM_EVERY_EDGE: edge_hit = rise || fall;
            CM_FALL: edge_hit = fall;
            CM_RISE, CM_WAKE: edge_hit = rise;
            CM_RISE4, CM_RISE16: edge_hit = rise && pre_hit;
            default: edge_hit = 1'b0;
        endcase
    end
    assign full = (fill_q == 3'(DEPTH));
    assign store = edge_hit && !full && !locked_q && (mode != CM_WAKE);
    assign c.head = mem_q[0];
    assign c.not_empty = (fill_q != 3'd0); // [R13]
    assign c.overflow = ovf_q;
    // Every-edge and wake modes flag each edge, else per count [R18] [R20]
    assign c.irq_pulse = edge_hit && ((mode == CM_EVERY_EDGE) || (mode == CM_WAKE) ||
                         (icnt_q == c.ctrl[CC_ICNT_LO +: 2]));
    assign c.wake = edge_hit && (mode == CM_WAKE); // [R19]
    // Edge prescaler cleared when channel off [R11]
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_q <= 1'b0;
            pre_q <= 4'h0;
            icnt_q <= 2'd0;
        end else begin
            pin_q <= c.pin;
            if (mode == CM_OFF) begin
                pre_q <= 4'h0;
                icnt_q <= 2'd0;
            end else begin
                if (rise && (mode == CM_RISE4 || mode == CM_RISE16)) begin
                    pre_q <= pre_hit ? 4'h0 : pre_q + 4'h1;
                end
                if (edge_hit && mode != CM_EVERY_EDGE) begin
                    icnt_q <= (icnt_q == c.ctrl[CC_ICNT_LO +: 2]) ? 2'd0 : icnt_q + 2'd1;
                end
            end
        end
    end
    // Buffer: read shifts forward, store at tail [R12] [R13] [R21]
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fill_q <= 3'd0;
            ovf_q <= 1'b0;
            locked_q <= 1'b0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= 16'h0000;
            end
        end else begin
            if (c.rd && fill_q != 3'd0) begin
                for (int i = 0; i < DEPTH - 1; i++) begin
                    mem_q[i] <= mem_q[i + 1];
                end
                fill_q <= fill_q - 3'd1;
                if (fill_q == 3'd1) begin
                    locked_q <= 1'b0; // [R14]
                end
            end else if (store) begin
                mem_q[fill_q[1:0]] <= c.timebase; // [R21]
                fill_q <= fill_q + 3'd1;
            end
            // Overflow set wins over software clear [R14] [R18]
            if (edge_hit && full && mode != CM_EVERY_EDGE && mode != CM_WAKE) begin
                ovf_q <= 1'b1;
                locked_q <= 1'b1;
            end else if (c.ctrl_wr && !c.ctrl[CC_OVF]) begin
                ovf_q <= 1'b0;
            end
        end
    end
endmodule : capture_channel
`default_nettype wire

// *** rtl/paired_timer_input_capture.sv ***
// Paired 16/32-bit timer with two-channel input capture
// Summary of operation
// [R1] High half pulses converter trigger on 32-bit or own 16-bit period match.
// [R2] Timer clock passes a prescaler dividing by 1, 8, 64 or 256.
// [R3] In 32-bit use the low timer clock and prescaler drive the pair.
// [R4] Prescaler clears on count or control writes and on reset.
// [R5] Low prescaler is not cleared while its timer is switched off.
// [R6] Writing a control register leaves the count unchanged.
// [R7] Timers stop counting while the CPU sleeps.
// [R8] High timer flag sets on pair period match or gate falling edge.
// [R9] Interrupt requested only while enabled; flag stays until software clears.
// [R10] Capture mode selects falling, rising, 4th, 16th rising or every edge.
// [R11] Capture edge prescaler clears when channel off and on reset.
// [R12] Each channel buffers four 16-bit captures.
// [R13] Not-empty flag holds until all read; reads shift entries forward.
// [R14] Capture when full sets overflow, is lost, stores halt until emptied.
// [R15] Software must not read an empty buffer; result undefined.
// [R16] Control bit 7 picks channel time base; high timer by default.
// [R17] Two independent capture channels, each with control and buffer.
// [R18] Every-edge mode flags each edge, ignores count field, never overflows.
// [R19] Mode 111 with interrupt enabled wakes the device regardless of timer.
// [R20] Control bits 6:5 choose capture events per interrupt.
// [R21] Qualifying edge stores selected timer's 16-bit count.
`default_nettype none
module paired_timer_input_capture (
    input wire logic clk,
    input wire logic rst,
    input wire logic [9:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic low_clk_pin,
    input wire logic high_clk_pin,
    input wire logic [1:0] capture_pin,
    input wire logic sleep,
    input wire logic idle,
    output logic converter_trigger,
    output logic irq_req,
    output logic wake_req
);
    import ptic_pkg::*;
    // Register state
    logic [15:0] low_cnt_q, high_cnt_q, hold_q, low_per_q, high_per_q;
    logic [15:0] low_ctl_q, high_ctl_q, cap_ctl_q [2];
    logic [15:0] irq_flag_q, irq_en_q, rdata_q;
    logic trig_q, wake_q;
    // Two-stage pin synchronisers
    logic [1:0] lck_s1, lck_s2, hck_s1, hck_s2, cp_s1, cp_s2;
    logic lck_d_q, hck_d_q, gate_d_q;
    // Decodes
    logic wr_low_cnt, wr_high_cnt, wr_low_ctl, wr_high_ctl, wr_hold, wr_lp, wr_hp;
    logic wide, low_on, high_on, run_ok_low, run_ok_high;
    logic low_tick, high_tick, low_en, high_en, low_clr, high_clr;
    logic low_gate, pair_match, low_match, high_match, gate_fall;
    logic [31:0] pair_cnt, pair_per;
    logic [1:0] cap_pulse, cap_wake;
    logic [15:0] cap_head [2];
    logic [1:0] cap_bne, cap_ovf;
    cap_if cif [2] ();

    function automatic logic hit(input logic [9:0] a, input logic [9:0] target);
        hit = (a == target);
    endfunction : hit

    assign wr_low_cnt = wr && hit(addr, ADDR_LOW_COUNT);
    assign wr_high_cnt = wr && hit(addr, ADDR_HIGH_COUNT);
    assign wr_low_ctl = wr && hit(addr, ADDR_LOW_CTRL);
    assign wr_high_ctl = wr && hit(addr, ADDR_HIGH_CTRL);
    assign wr_hold = wr && hit(addr, ADDR_HOLDING);
    assign wr_lp = wr && hit(addr, ADDR_LOW_PERIOD);
    assign wr_hp = wr && hit(addr, ADDR_HIGH_PERIOD);

    // Synchronise every external pin through two stages
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lck_s1 <= 2'b00;
            hck_s1 <= 2'b00;
            cp_s1 <= 2'b00;
            lck_s2 <= 2'b00;
            hck_s2 <= 2'b00;
            cp_s2 <= 2'b00;
        end else begin
            lck_s1 <= {1'b0, low_clk_pin};
            hck_s1 <= {1'b0, high_clk_pin};
            cp_s1 <= capture_pin;
            lck_s2 <= lck_s1;
            hck_s2 <= hck_s1;
            cp_s2 <= cp_s1;
        end
    end

    // Clock and gate selection; sleep halts all counting [R7]
    assign wide = low_ctl_q[TC_WIDE];
    assign run_ok_low = !sleep && !(idle && low_ctl_q[TC_IDLE]);
    assign run_ok_high = !sleep && !(idle && high_ctl_q[TC_IDLE]);
    assign low_on = low_ctl_q[TC_ON] && run_ok_low;
    assign high_on = high_ctl_q[TC_ON] && run_ok_high && !wide;
    assign low_gate = low_ctl_q[TC_GATE] && !low_ctl_q[TC_SRC];
    assign low_tick = low_on && (low_ctl_q[TC_SRC] ? (lck_s2[0] && !lck_d_q)
                      : (low_gate ? lck_s2[0] : 1'b1));
    assign high_tick = high_on && (high_ctl_q[TC_SRC] ? (hck_s2[0] && !hck_d_q) : 1'b1);
    assign gate_fall = low_gate && low_ctl_q[TC_ON] && !lck_s2[0] && gate_d_q;
    // Only the low timer keeps its prescaler while off; writes clear it [R4] [R5]
    assign low_clr = low_ctl_q[TC_ON] && (wr_low_cnt || wr_low_ctl);
    assign high_clr = wr_high_cnt || wr_high_ctl;

    div_prescaler u_low_div (
        .clk(clk),
        .rst(rst),
        .tick(low_tick),
        .clear(low_clr),
        .sel(low_ctl_q[TC_DIV_LO +: 2]), // [R2]
        .en(low_en)
    );
    div_prescaler u_high_div (
        .clk(clk),
        .rst(rst),
        .tick(high_tick),
        .clear(high_clr),
        .sel(high_ctl_q[TC_DIV_LO +: 2]),
        .en(high_en)
    );

    // Match decodes
    assign pair_cnt = {high_cnt_q, low_cnt_q};
    assign pair_per = {high_per_q, low_per_q};
    assign pair_match = wide && (pair_cnt == pair_per);
    assign low_match = !wide && (low_cnt_q == low_per_q);
    assign high_match = !wide && (high_cnt_q == high_per_q);

    // Counters; pair mode uses the low prescaler only [R3]
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_cnt_q <= 16'h0000;
            high_cnt_q <= 16'h0000;
            lck_d_q <= 1'b0;
            hck_d_q <= 1'b0;
            gate_d_q <= 1'b0;
        end else begin
            lck_d_q <= lck_s2[0];
            hck_d_q <= hck_s2[0];
            gate_d_q <= lck_s2[0];
            if (wr_low_cnt) begin
                low_cnt_q <= wdata;
            end else if (low_en) begin
                low_cnt_q <= (pair_match || low_match) ? 16'h0000 : low_cnt_q + 16'h0001;
            end
            // Holding word loads high half on low write in 32-bit mode
            if (wr_low_cnt && wide) begin
                high_cnt_q <= hold_q;
            end else if (wr_high_cnt) begin
                high_cnt_q <= wdata;
            end else if (wide && low_en) begin
                high_cnt_q <= pair_match ? 16'h0000 :
                              high_cnt_q + {15'h0000, low_cnt_q == 16'hffff}; // [R3]
            end else if (high_en) begin
                high_cnt_q <= high_match ? 16'h0000 : high_cnt_q + 16'h0001;
            end
        end
    end

    // Control and period registers [R6]
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_ctl_q <= CTRL_RESET;
            high_ctl_q <= CTRL_RESET;
            low_per_q <= PERIOD_RESET;
            high_per_q <= PERIOD_RESET;
            hold_q <= 16'h0000;
            irq_en_q <= 16'h0000;
        end else begin
            if (wr_low_ctl) low_ctl_q <= wdata; // [R6]
            if (wr_high_ctl) high_ctl_q <= wdata;
            if (wr_lp) low_per_q <= wdata;
            if (wr_hp) high_per_q <= wdata;
            if (wr_hold) hold_q <= wdata;
            if (wr && hit(addr, ADDR_IRQ_ENABLE)) irq_en_q <= wdata;
        end
    end

    // Trigger pulse per count-restarting match [R1]
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= (wide && low_en && pair_match) || (!wide && high_en && high_match); // [R1]
        end
    end
    assign converter_trigger = trig_q;

    // Capture channels [R17]
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_cap
            logic ctl_wr;
            assign ctl_wr = wr && hit(addr, g ? ADDR_CAP1_CTRL : ADDR_CAP0_CTRL);
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    cap_ctl_q[g] <= CTRL_RESET;
                end else if (ctl_wr) begin
                    cap_ctl_q[g] <= wdata;
                end
            end
            assign cif[g].ctrl = cap_ctl_q[g];
            assign cif[g].ctrl_wr = ctl_wr;
            // Bit 7 clear picks the high timer, the reset default [R16]
            assign cif[g].timebase = cap_ctl_q[g][CC_TB] ? low_cnt_q : high_cnt_q;
            assign cif[g].pin = cp_s2[g];
            assign cif[g].rd = rd && hit(addr, g ? ADDR_CAP1_BUF : ADDR_CAP0_BUF);
            assign cap_head[g] = cif[g].head;
            assign cap_bne[g] = cif[g].not_empty;
            assign cap_ovf[g] = cif[g].overflow;
            assign cap_pulse[g] = cif[g].irq_pulse;
            assign cap_wake[g] = cif[g].wake;
            capture_channel #(.DEPTH(CAP_DEPTH)) u_chan (
                .clk(clk),
                .rst(rst),
                .c(cif[g])
            );
        end
    endgenerate

    // Sticky flags, hardware set wins [R8] [R9]
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_flag_q <= 16'h0000;
            wake_q <= 1'b0;
        end else begin
            if (wr && hit(addr, ADDR_IRQ_FLAG)) begin
                irq_flag_q <= wdata;
            end
            if ((wide && low_en && pair_match) || (!wide && high_en && high_match) ||
                    (wide && gate_fall)) begin
                irq_flag_q[IRQ_HIGH_TIMER] <= 1'b1; // [R8]
            end
            if (cap_pulse[0]) irq_flag_q[IRQ_CAP0] <= 1'b1;
            if (cap_pulse[1]) irq_flag_q[IRQ_CAP1] <= 1'b1;
            // Wake needs channel enable, not timer [R19]
            wake_q <= (cap_wake[0] && irq_en_q[IRQ_CAP0]) || (cap_wake[1] && irq_en_q[IRQ_CAP1]);
        end
    end
    assign irq_req = |(irq_flag_q & irq_en_q); // [R9]
    assign wake_req = wake_q;

    // Read data one cycle after the strobe; unmapped reads as zero.
    // Empty buffer read gives stale head data [R15]
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 16'h0000;
        end else if (rd) begin
            case (addr)
                ADDR_LOW_COUNT: rdata_q <= low_cnt_q;
                ADDR_HOLDING: rdata_q <= hold_q;
                ADDR_HIGH_COUNT: rdata_q <= high_cnt_q;
                ADDR_LOW_PERIOD: rdata_q <= low_per_q;
                ADDR_HIGH_PERIOD: rdata_q <= high_per_q;
                ADDR_LOW_CTRL: rdata_q <= low_ctl_q;
                ADDR_HIGH_CTRL: rdata_q <= high_ctl_q;
                ADDR_CAP0_BUF: rdata_q <= cap_head[0];
                ADDR_CAP1_BUF: rdata_q <= cap_head[1];
                ADDR_CAP0_CTRL: rdata_q <= {cap_ctl_q[0][15:5], cap_ovf[0], cap_bne[0],
                                            cap_ctl_q[0][2:0]};
                ADDR_CAP1_CTRL: rdata_q <= {cap_ctl_q[1][15:5], cap_ovf[1], cap_bne[1],
                                            cap_ctl_q[1][2:0]};
                ADDR_IRQ_FLAG: rdata_q <= irq_flag_q;
                ADDR_IRQ_ENABLE: rdata_q <= irq_en_q;
                default: rdata_q <= 16'h0000;
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end
    assign rdata = rdata_q;
endmodule : paired_timer_input_capture
`default_nettype wire

// *** verif/paired_timer_input_capture_properties.sv ***
// Port-level checker for the timer and capture unit
`default_nettype none
module ptic_checker
    import ptic_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [9:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire logic [1:0] capture_pin,
    input wire logic sleep,
    input wire logic converter_trigger,
    input wire logic irq_req,
    input wire logic wake_req
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Stale read data must never leak
    a_rdata_idle: assert property (!rd |=> rdata == 16'h0000)
        else $error("stray read data");
    a_unmapped_zero: assert property (rd && addr == 10'h3fe |=> rdata == 16'h0000)
        else $error("unmapped read nonzero");
    a_reset_quiet: assert property ($fell(rst) |-> !converter_trigger && !irq_req && !wake_req)
        else $error("output active after reset");
    // One cycle of pipeline may finish a match
    a_sleep_halts: assert property (sleep [*4] |-> !converter_trigger)
        else $error("trigger while sleeping");
    a_enable_gate: assert property (wr && addr == ADDR_IRQ_ENABLE && wdata == 16'h0000 |=> !irq_req)
        else $error("request with enables clear");
    a_flag_hold: assert property (irq_req && !wr |=> irq_req)
        else $error("request dropped without write");
    a_wake_single: assert property (wake_req |=> !wake_req)
        else $error("wake longer than one cycle");
    a_wake_cause: assert property ((capture_pin == $past(capture_pin)) [*8] |-> !wake_req)
        else $error("wake without a pin edge");
endmodule : ptic_checker

bind paired_timer_input_capture ptic_checker chk_u (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .capture_pin(capture_pin), .sleep(sleep),
    .converter_trigger(converter_trigger), .irq_req(irq_req), .wake_req(wake_req));
`default_nettype wire

// *** verif/edge_source.sv ***
// Far-side model of capture and timer pins
`default_nettype none
module edge_source (
    input wire logic clk,
    output var logic [1:0] capture_pin,
    output var logic low_clk_pin,
    output var logic high_clk_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // External clock and gate stay low, so only the internal clock counts
    initial begin
        capture_pin = 2'b00;
        low_clk_pin = 1'b0;
        high_clk_pin = 1'b0;
    end
    // One pulse, each level held past the two-flop sync
    task automatic pulse(input int ch, input int hold);
        @(posedge clk);
        capture_pin[ch] <= 1'b1;
        repeat (hold) @(posedge clk);
        capture_pin[ch] <= 1'b0;
        repeat (hold) @(posedge clk);
    endtask : pulse
endmodule : edge_source
`default_nettype wire

// *** verif/paired_timer_input_capture_tb.sv ***
// Self-checking bench for the timer and capture unit
`default_nettype none
module paired_timer_input_capture_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ptic_pkg::*;
    logic clk, rst, wr, rd, sleep, idle, converter_trigger, irq_req, wake_req;
    logic low_clk_pin, high_clk_pin;
    logic [1:0] capture_pin;
    logic [9:0] addr;
    logic [15:0] wdata, rdata, v;
    int failures = 0;
    int num_checks = 0;
    int trigs = 0, wakes = 0;
    int n, t0;
    logic [9:0] ra [7] = '{ADDR_LOW_COUNT, ADDR_HIGH_COUNT, ADDR_LOW_PERIOD,
        ADDR_HIGH_PERIOD, ADDR_LOW_CTRL, ADDR_HIGH_CTRL, 10'h3fe};
    logic [15:0] rv [7] = '{16'h0000, 16'h0000, PERIOD_RESET, PERIOD_RESET,
        CTRL_RESET, CTRL_RESET, 16'h0000};
    int div [4] = '{1, 8, 64, 256};
    cap_mode_t modes [7] = '{CM_FALL, CM_RISE, CM_RISE4, CM_RISE4, CM_RISE4,
        CM_RISE16, CM_EVERY_EDGE};
    int pulses [7] = '{4, 4, 3, 3, 4, 4, 3};
    int stored [7] = '{4, 4, 0, 0, 1, 0, 4};

    paired_timer_input_capture dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .low_clk_pin(low_clk_pin),
        .high_clk_pin(high_clk_pin), .capture_pin(capture_pin), .sleep(sleep), .idle(idle),
        .converter_trigger(converter_trigger), .irq_req(irq_req), .wake_req(wake_req));
    edge_source src_u (.clk(clk), .capture_pin(capture_pin), .low_clk_pin(low_clk_pin),
        .high_clk_pin(high_clk_pin));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Pulse counters; scenarios take differences
    always @(posedge clk) begin
        if (converter_trigger === 1'b1) trigs++;
        if (wake_req === 1'b1) wakes++;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // An idle edge before each strobe avoids double assignment
    task automatic wr_reg(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [9:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask : rd_reg
    task automatic end_of_test;
        if (failures == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        rst = 1'b1; addr = 10'h000; wdata = 16'h0000; wr = 1'b0; rd = 1'b0;
        sleep = 1'b0; idle = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // Reset values, unmapped place last
        for (int i = 0; i < 7; i++) begin
            rd_reg(ra[i], v);
            check("reset value", 32'(v), 32'(rv[i]));
        end
        wr_reg(ADDR_LOW_COUNT, 16'h1234);
        wr_reg(ADDR_LOW_CTRL, 16'h0030);
        rd_reg(ADDR_LOW_COUNT, v);
        check("count after control write", 32'(v), 32'h1234);
        // 64 periods per divide setting; write latency gives some spread
        for (int s = 0; s < 4; s++) begin
            wr_reg(ADDR_LOW_COUNT, 16'h0000);
            wr_reg(ADDR_LOW_CTRL, 16'h8000 | (16'(s) << TC_DIV_LO));
            repeat (64 * div[s]) @(posedge clk);
            wr_reg(ADDR_LOW_CTRL, 16'(s) << TC_DIV_LO);
            rd_reg(ADDR_LOW_COUNT, v);
            check("divided count", 32'(v >= 16'd62 && v <= 16'd66), 32'h1);
        end
        // 16-bit high timer, period 9: a trigger per ten cycles, none asleep
        wr_reg(ADDR_HIGH_PERIOD, 16'h0009);
        wr_reg(ADDR_HIGH_COUNT, 16'h0000);
        wr_reg(ADDR_HIGH_CTRL, 16'h8000);
        t0 = trigs;
        repeat (200) @(posedge clk);
        check("trigger count", 32'(trigs - t0 >= 19 && trigs - t0 <= 21), 32'h1);
        sleep <= 1'b1;
        repeat (4) @(posedge clk);
        t0 = trigs;
        repeat (200) @(posedge clk);
        check("sleep triggers", 32'(trigs - t0), 32'h0);
        sleep <= 1'b0;
        wr_reg(ADDR_HIGH_CTRL, 16'h0000);
        // Wide pair, period 0x14, flag on pair match; wide set first so holding loads
        wr_reg(ADDR_LOW_CTRL, 16'h0008);
        wr_reg(ADDR_LOW_PERIOD, 16'h0014);
        wr_reg(ADDR_HIGH_PERIOD, 16'h0000);
        wr_reg(ADDR_HOLDING, 16'h0000);
        wr_reg(ADDR_LOW_COUNT, 16'h0000);
        wr_reg(ADDR_IRQ_ENABLE, 16'h0080);
        wr_reg(ADDR_LOW_CTRL, 16'h8008);
        for (n = 0; n < 100 && irq_req !== 1'b1; n++) @(posedge clk);
        check("pair irq", 32'(irq_req), 32'h1);
        if (irq_req !== 1'b1) end_of_test;
        wr_reg(ADDR_IRQ_ENABLE, 16'h0000);
        @(posedge clk);
        check("masked irq", 32'(irq_req), 32'h0);
        wr_reg(ADDR_LOW_CTRL, 16'h0000);
        rd_reg(ADDR_IRQ_FLAG, v);
        check("flag held", 32'(v[IRQ_HIGH_TIMER]), 32'h1);
        wr_reg(ADDR_IRQ_FLAG, 16'h0000);
        rd_reg(ADDR_IRQ_FLAG, v);
        check("flag cleared", 32'(v[IRQ_HIGH_TIMER]), 32'h0);
        // Five stamps into a four-deep buffer
        wr_reg(ADDR_CAP0_CTRL, 16'h0003);
        for (int i = 0; i < 5; i++) begin
            wr_reg(ADDR_HIGH_COUNT, 16'h00a0 + 16'(i));
            src_u.pulse(0, 6);
        end
        rd_reg(ADDR_CAP0_CTRL, v);
        check("full status", 32'(v[4:3]), 32'h3);
        for (int i = 0; i < 4; i++) begin
            rd_reg(ADDR_CAP0_BUF, v);
            check("buffer entry", 32'(v), 32'h00a0 + i);
        end
        rd_reg(ADDR_CAP0_CTRL, v);
        check("empty flag", 32'(v[CC_BNE]), 32'h0);
        wr_reg(ADDR_HIGH_COUNT, 16'h00b0);
        src_u.pulse(0, 12);
        rd_reg(ADDR_CAP0_BUF, v);
        check("after drain", 32'(v), 32'h00b0);
        // Each mode; repeated divide-by-4 rows prove the off clear
        for (int m = 0; m < 7; m++) begin
            wr_reg(ADDR_CAP0_CTRL, 16'h0000);
            wr_reg(ADDR_CAP0_CTRL, {13'h0000, modes[m]});
            repeat (pulses[m]) src_u.pulse(0, 6);
            rd_reg(ADDR_CAP0_CTRL, v);
            check("overflow", 32'(v[CC_OVF]), 32'h0);
            n = 0;
            // Read only while data is reported
            while (v[CC_BNE] === 1'b1 && n < 8) begin
                rd_reg(ADDR_CAP0_BUF, v);
                n++;
                rd_reg(ADDR_CAP0_CTRL, v);
            end
            check("stored count", 32'(n), 32'(stored[m]));
            if (n >= 8) end_of_test;
        end
        // Second channel on the low timer
        wr_reg(ADDR_CAP1_CTRL, 16'h0083);
        wr_reg(ADDR_LOW_COUNT, 16'h0777);
        src_u.pulse(1, 6);
        rd_reg(ADDR_CAP0_CTRL, v);
        check("other channel", 32'(v[CC_BNE]), 32'h0);
        rd_reg(ADDR_CAP1_BUF, v);
        check("low timebase", 32'(v), 32'h0777);
        // Wake from sleep with every timer stopped
        wr_reg(ADDR_CAP0_CTRL, {13'h0000, CM_WAKE});
        wr_reg(ADDR_IRQ_FLAG, 16'h0000);
        wr_reg(ADDR_IRQ_ENABLE, 16'h0002);
        sleep <= 1'b1;
        n = wakes;
        src_u.pulse(0, 6);
        check("wake pulses", 32'(wakes - n), 32'h1);
        check("capture irq", 32'(irq_req), 32'h1);
        sleep <= 1'b0;
        end_of_test;
    end
endmodule : paired_timer_input_capture_tb
`default_nettype wire
